// >>> verilog/startup_pkg.sv
/*
 * Constants and carrier types for the power-up sequencer of the module variant
 * without keys or display.
 * Assumes one 50 MHz clock and a synchronous active-low power-on reset.
 */
package startup_pkg;

    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned SETTLE_US = 10;
    localparam int unsigned SETTLE_CYCLES = (SETTLE_US * (CLK_HZ / 1_000_000));
    localparam int unsigned SETTLE_W = 16;

    typedef enum logic [2:0] {
        ST_SETTLE = 3'b000,
        ST_PROBE = 3'b001,
        ST_COPY = 3'b010,
        ST_CHECK = 3'b011,
        ST_PC_LINK = 3'b100,
        ST_RUN = 3'b101,
        ST_STOP = 3'b110
    } run_state_t;

    // Status toward the rest of the module.
    typedef struct packed {
        logic run;
        logic pc_link_mode;
        logic copy_busy;
        logic red_led;
        logic green_led;
    } run_status_t;

    // Handshake to the card copy engine.
    typedef struct packed {
        logic start;
    } copy_req_t;

endpackage : startup_pkg

// >>> verilog/headless_startup_run_control.sv
/*
 * Power-up sequencer and run-state LED driver for the headless variant.
 * Assumes card and cable detect are pins (synchronised here); copy engine
 * and program-valid flag are on the same clock.
 */
`timescale 1ns/1ps
module headless_startup_run_control (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Presence pins
    input wire logic card_present,
    input wire logic pc_cable_present,
    // Program memory and copy engine
    input wire logic prog_valid,
    input wire logic copy_done,
    output startup_pkg::copy_req_t copy_req,
    // Keys, accepted but ignored on this variant
    input wire logic [3:0] keys,
    // Status and LEDs
    output startup_pkg::run_status_t status
);
    import startup_pkg::*;

    // The LEDs follow RUN alone; red covers every state that is not RUN.
    function automatic run_status_t status_of(input run_state_t s);
        run_status_t r;
        r = '0;
        case (s)
            ST_RUN: begin
                r.run = 1'b1;
                r.green_led = 1'b1;
            end
            ST_PC_LINK: begin
                r.pc_link_mode = 1'b1;
                r.red_led = 1'b1;
            end
            ST_COPY: begin
                r.copy_busy = 1'b1;
                r.red_led = 1'b1;
            end
            // Settle, probe, check and stop all show red only.
            default: begin
                r.red_led = 1'b1;
            end
        endcase
        return r;
    endfunction : status_of

    // Shifts one pin sample into a two-stage synchroniser.
    function automatic logic [1:0] sync_shift(input logic [1:0] q, input logic pin);
        return {q[0], pin};
    endfunction : sync_shift

    // Terminal count of the settle counter.
    function automatic logic settle_end(input logic [SETTLE_W-1:0] cnt);
        return (cnt == SETTLE_W'(SETTLE_CYCLES - 1));
    endfunction : settle_end

    // Presence pins after two flip-flops.
    logic [1:0] card_sync_q;
    logic [1:0] card_sync_d;
    logic [1:0] cable_sync_q;
    logic [1:0] cable_sync_d;
    logic card_seen;
    logic cable_seen;

    // Settle counter.
    logic [SETTLE_W-1:0] cnt_q;
    logic [SETTLE_W-1:0] cnt_d;
    logic settle_done;

    // Sequencer state and copy start pulse.
    run_state_t state_q;
    run_state_t state_d;
    logic start_q;
    logic start_d;

    // Registered status word.
    run_status_t status_q;
    run_status_t status_d;

    logic unused_keys;

    // Keys never influence state on this variant.
    assign unused_keys = |keys;

    // Only the second stage of each synchroniser feeds the sequencer.
    assign card_seen = card_sync_q[1];
    assign cable_seen = cable_sync_q[1];

    always_comb begin
        card_sync_d = sync_shift(card_sync_q, card_present);
        cable_sync_d = sync_shift(cable_sync_q, pc_cable_present);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            card_sync_q <= 2'h0;
            cable_sync_q <= 2'h0;
        end else begin
            card_sync_q <= card_sync_d;
            cable_sync_q <= cable_sync_d;
        end
    end

    // The settle counter runs only in the settle state and then holds.
    assign settle_done = settle_end(cnt_q);

    always_comb begin
        cnt_d = cnt_q;
        if ((state_q == ST_SETTLE) && !settle_done) begin
            cnt_d = cnt_q + SETTLE_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // The sequencer passes through its decisions once per power-on and then parks.
    always_comb begin
        state_d = state_q;
        case (state_q)
            // Wait for the presence pins to settle after power-on.
            ST_SETTLE: begin
                if (settle_done) begin
                    state_d = ST_PROBE;
                end
            end
            // A card wins over a cable; with neither, the stored program decides.
            ST_PROBE: begin
                if (card_seen) begin
                    state_d = ST_COPY;
                end else if (cable_seen) begin
                    state_d = ST_PC_LINK;
                end else begin
                    state_d = ST_CHECK;
                end
            end
            // After the copy engine reports the end, a cable leads to link; without one, validity is judged.
            ST_COPY: begin
                if (copy_done) begin
                    if (cable_seen) begin
                        state_d = ST_PC_LINK;
                    end else begin
                        state_d = ST_CHECK;
                    end
                end
            end
            // A missing or broken program parks in STOP with the red LED lit.
            ST_CHECK: begin
                if (prog_valid) begin
                    state_d = ST_RUN;
                end else begin
                    state_d = ST_STOP;
                end
            end
            // Link, run and stop hold until the next power-on.
            ST_PC_LINK: begin
                state_d = ST_PC_LINK;
            end
            ST_RUN: begin
                state_d = ST_RUN;
            end
            ST_STOP: begin
                state_d = ST_STOP;
            end
            // Any unused code returns to settle; the settle counter is not cleared, so probe follows at once.
            default: begin
                state_d = ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= ST_SETTLE;
        end else begin
            state_q <= state_d;
        end
    end

    // One-cycle start pulse on the step from probe into copy.
    always_comb begin
        start_d = 1'b0;
        if ((state_q == ST_PROBE) && (state_d == ST_COPY)) begin
            start_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_d;
        end
    end

    // Status is registered from the next state so it moves with the state register.
    always_comb begin
        status_d = status_of(state_d);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_q <= status_of(ST_SETTLE);
        end else begin
            status_q <= status_d;
        end
    end

    // Both outputs come straight from flip-flops.
    assign copy_req.start = start_q;
    assign status = status_q;

endmodule : headless_startup_run_control

// >>> bench/startup_asserts.sv
/* Checker for the startup sequencer. Sees only its ports. */
`timescale 1ns/1ps
module startup_asserts (
    input wire logic clk,
    input wire logic resetn,
    input startup_pkg::copy_req_t copy_req,
    input startup_pkg::run_status_t status
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_red_not_run: assert property (status.red_led == !status.run)
        else $error("red led wrong");
    a_green_is_run: assert property (status.green_led == status.run)
        else $error("green led wrong");
    a_run_holds: assert property (status.run |=> status.run)
        else $error("run left");
    a_link_no_run: assert property (status.pc_link_mode |-> !status.run)
        else $error("link ran");
    a_copy_busy: assert property (copy_req.start |-> status.copy_busy)
        else $error("busy missing");
    a_copy_first: assert property (status.copy_busy |-> !status.run)
        else $error("ran in copy");
    a_start_single: assert property (copy_req.start |=> !copy_req.start)
        else $error("start held");
    a_copy_started: assert property ($rose(status.copy_busy) |-> copy_req.start)
        else $error("copy without start");
    a_copy_then_check: assert property (status.copy_busy |=> !status.run)
        else $error("ran after copy");
    a_link_holds: assert property (status.pc_link_mode |=> status.pc_link_mode)
        else $error("link left");
    cover property (status.run);
    cover property (status.pc_link_mode);
    cover property (copy_req.start);
    cover property (status.copy_busy ##1 !status.copy_busy);
endmodule : startup_asserts
bind headless_startup_run_control startup_asserts u_chk (.clk(clk), .resetn(resetn),
    .copy_req(copy_req), .status(status));

// >>> bench/card_model.sv
/* Card copy engine. Answers a start pulse with done after d cycles. */
`timescale 1ns/1ps
module card_model #(parameter int D = 20) (
    input wire logic clk,
    input startup_pkg::copy_req_t req,
    output logic done = 1'b0
);
    int n = 0;
    always @(posedge clk) begin
        done <= (n == 1);
        n <= req.start ? D : (n > 0 ? n - 1 : 0);
    end
endmodule : card_model

// >>> bench/tb_top.sv
/* Bench for the startup sequencer. Uses card_model as copy engine. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
    $display("[FAIL] %s exp %b got %b", n, e, s); end end
module tb_top;
    import startup_pkg::*;
    localparam int SETTLE = int'(SETTLE_CYCLES);
    localparam int COPY_CYCLES = 20;
    logic clk = 0, resetn = 0, card = 0, cable = 0, valid = 0, done;
    logic [3:0] keys = 4'h0;
    copy_req_t req;
    run_status_t st;
    int n_errors = 0, checked = 0, cyc = 0, since_rel = 0;
    always #10 clk = ~clk;
    card_model #(.D(COPY_CYCLES)) u_card (.clk(clk), .req(req), .done(done));
    headless_startup_run_control u_dut (.clk(clk), .resetn(resetn), .card_present(card),
        .pc_cable_present(cable), .prog_valid(valid), .copy_done(done),
        .copy_req(req), .keys(keys), .status(st));
    task results;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    // Counts cycles for the timeout and edges since reset release for the scenarios.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        since_rel <= resetn ? since_rel + 1 : 0;
        if (cyc == 6000) begin
            n_errors++;
            results;
        end
    end
    // Applies power-on reset with the given pins and checks the outputs while held.
    task power_up(input logic c, input logic p, input logic v);
        @(posedge clk);
        #1;
        resetn = 1'b0;
        card = c;
        cable = p;
        valid = v;
        keys = 4'h0;
        repeat (6) @(posedge clk);
        #1;
        `CHK("reset status", 5'h02, st)
        `CHK("reset start", 1'b0, req.start)
        resetn = 1'b1;
    endtask : power_up
    // Returns just after the given edge, counted from reset release.
    task to_edge(input int n);
        while (since_rel != n) begin
            @(posedge clk);
            #1;
        end
    endtask : to_edge
    task scen_card_copy;
        power_up(1'b1, 1'b0, 1'b1);
        keys = 4'hf;
        to_edge(SETTLE - 1);
        `CHK("settle", 5'h02, st)
        to_edge(SETTLE + 1);
        `CHK("copy start", 1'b1, req.start)
        `CHK("copy state", 5'h06, st)
        to_edge(SETTLE + 2);
        `CHK("start pulse", 1'b0, req.start)
        to_edge(SETTLE + COPY_CYCLES + 2);
        `CHK("copy wait", 5'h06, st)
        to_edge(SETTLE + COPY_CYCLES + 3);
        `CHK("check after copy", 5'h02, st)
        to_edge(SETTLE + COPY_CYCLES + 4);
        `CHK("run after copy", 5'h11, st)
    endtask : scen_card_copy
    task scen_pc_link;
        power_up(1'b0, 1'b1, 1'b1);
        to_edge(SETTLE);
        `CHK("probe", 5'h02, st)
        to_edge(SETTLE + 1);
        `CHK("link entry", 5'h0a, st)
        `CHK("link no copy", 1'b0, req.start)
        keys = 4'hf;
        to_edge(SETTLE + 40);
        `CHK("link holds", 5'h0a, st)
    endtask : scen_pc_link
    task scen_valid_run;
        power_up(1'b0, 1'b0, 1'b1);
        to_edge(SETTLE + 1);
        `CHK("check", 5'h02, st)
        to_edge(SETTLE + 2);
        `CHK("run", 5'h11, st)
        keys = 4'hf;
        to_edge(SETTLE + 20);
        `CHK("run keys", 5'h11, st)
    endtask : scen_valid_run
    task scen_empty_stop;
        power_up(1'b0, 1'b0, 1'b0);
        to_edge(SETTLE + 2);
        `CHK("stop", 5'h02, st)
        keys = 4'hf;
        to_edge(SETTLE + 20);
        `CHK("stop keys", 5'h02, st)
    endtask : scen_empty_stop
    task scen_card_cable;
        power_up(1'b1, 1'b1, 1'b1);
        to_edge(SETTLE + 1);
        `CHK("card first", 1'b1, req.start)
        to_edge(SETTLE + COPY_CYCLES + 3);
        `CHK("link after copy", 5'h0a, st)
        to_edge(SETTLE + COPY_CYCLES + 40);
        `CHK("link no run", 5'h0a, st)
    endtask : scen_card_cable
    initial begin
        scen_card_copy();
        scen_pc_link();
        scen_valid_run();
        scen_empty_stop();
        scen_card_cable();
        results();
    end
endmodule : tb_top
